// File: hdl/bsw_defs.svh
// Functional notes
// [RULE1] Switchover enabled at reset; config bit1 disables
// [RULE2] Peripheral config bit6 shows rail source
// [RULE3] Low DC monitor switches when program clear
// [RULE4] Low main switches when program bit1 clear
// [RULE5] Pin rising edge switches when pin enabled
// [RULE6] Pin enabled when pin config 4:2 x01
// [RULE7] Return only when all enabled conditions false
// [RULE8] DC-enabled return needs both supplies qualified
// [RULE9] Main-only return needs main supply qualified
// [RULE10] Pin-enabled return also needs pin low
// [RULE11] Shared interrupt off until master enable set
// [RULE12] Per-source enables share one interrupt
// [RULE13] Event flags latch until software write
// [RULE14] Main-to-battery change sets switchover flag
// [RULE15] Battery-to-main change sets restore flag
// [RULE16] Flags set regardless of enables
// [RULE17] Software clears flags by writing zero
// [RULE18] DC conversion delta beyond threshold flags event
// [RULE19] Periodic or started conversion sets ready flag
// [RULE20] Battery low or new reading sets flag
// [RULE21] DC monitor below 1.2V sets low flag
// [RULE22] Core keeps running through switchover
// [RULE23] Request is OR of each flag ANDed with its enable, masked
// [RULE24] Line sag sets sag flag, enable gates
//
// Purpose: Register addresses, bit positions and timing counts
// Assumes: Included by bare name
// Notes: Offsets are special-function addresses
`ifndef BSW_DEFS_SVH
`define BSW_DEFS_SVH

`define BSW_ADDR_IEIP_TWO 8'ha9
`define BSW_ADDR_ADC_START 8'hd8
`define BSW_ADDR_BAT_READ 8'hdf
`define BSW_ADDR_EVT_EN 8'hec
`define BSW_ADDR_ADC_DELTA 8'hf3
`define BSW_ADDR_PERIPHERAL_CONFIG 8'hf4
`define BSW_ADDR_SWO_CFG 8'hf5
`define BSW_ADDR_EVT_FLAGS 8'hf8
`define BSW_ADDR_BAT_THR 8'hfa
`define BSW_ADDR_PIN_CFG 8'hff

`define BSW_BIT_SWO_DIS 1
`define BSW_BIT_PROG_HI 1
`define BSW_BIT_PROG_LO 0
`define BSW_BIT_SRC 6
`define BSW_BIT_MASTER 1
`define BSW_PIN_LO 2
`define BSW_PIN_HI 4
`define BSW_PIN_PATTERN 2'h1

// Event bit positions, shared by flag and enable registers
`define BSW_EV_DCLOW 0
`define BSW_EV_SAG 1
`define BSW_EV_DELTA 2
`define BSW_EV_READY 3
`define BSW_EV_BATT 4
`define BSW_EV_SWO 5
`define BSW_EV_RESTORE 6

`define BSW_RST_SWO_CFG 8'h01
`define BSW_RST_ZERO 8'h00

`define BSW_QUAL_TIME_US 1000
`define BSW_CLK_MHZ 200
`define BSW_QUAL_CYCLES (`BSW_QUAL_TIME_US * `BSW_CLK_MHZ)
`define BSW_BG_TIME_US 100
`define BSW_BG_CYCLES (`BSW_BG_TIME_US * `BSW_CLK_MHZ)

`endif

// File: hdl/bsw_pkg.sv
// Purpose: Types for the supply switchover block
// Assumes: Core special-function bus on one clock
// Notes: Holds types only
package bsw_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bsw_sfr_req_t;

  typedef struct packed {
    logic main_low;
    logic dc_low;
    logic line_sag;
    logic bat_ready;
    logic [7:0] bat_value;
    logic dc_ready;
    logic [7:0] dc_value;
  } bsw_mon_t;

  typedef enum logic {BSW_ON_MAIN, BSW_ON_BATT} bsw_src_t;
endpackage

// File: hdl/bsw_switchover.sv
// Purpose: Rail source selection and supply-monitor interrupt
// Assumes: Comparator inputs asynchronous; pin asynchronous
// Notes: Reads return data one cycle after the read strobe
`timescale 1ns/10ps
`include "bsw_defs.svh"

module bsw_switchover
  import bsw_pkg::*;
#(
  parameter int unsigned QUAL_CYCLES = `BSW_QUAL_CYCLES,
  parameter int unsigned BG_CYCLES = `BSW_BG_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Core special-function bus
  input wire bsw_sfr_req_t sfr_req_in,
  output logic [7:0] sfr_rdata_out,
  // Supply monitors and pin
  input wire bsw_mon_t mon_in,
  input wire logic battery_control_pin_in,
  // Outputs
  output logic rail_on_battery_out,
  output logic aux_adc_start_out,
  output logic supply_monitor_interrupt_out
);

  // Two-stage synchronisers for async inputs
  localparam int NSYNC = 4;
  logic [NSYNC-1:0] async_in, s1_reg, s2_reg, s1_next, s2_next;
  logic pin_prev_reg, pin_prev_next;

  // Registers
  logic [7:0] iep2_reg, iep2_next;
  logic [7:0] evt_en_reg, evt_en_next;
  logic [7:0] delta_reg, delta_next;
  logic [7:0] swo_cfg_reg, swo_cfg_next;
  logic [7:0] flags_reg, flags_next;
  logic [7:0] bat_thr_reg, bat_thr_next;
  logic [7:0] pin_cfg_reg, pin_cfg_next;
  logic [7:0] bat_read_reg, bat_read_next;
  logic [7:0] dc_prev_reg, dc_prev_next;
  logic [7:0] rdata_reg, rdata_next;
  logic start_reg, start_next;
  bsw_src_t src_reg, src_next;
  logic [31:0] qual_cnt_reg, qual_cnt_next;
  logic [31:0] bg_cnt_reg, bg_cnt_next;

  logic main_low, dc_low, sag, pin_now;
  logic pin_en, dc_en, main_en, sw_dis, go_batt, can_return, rising;
  logic [7:0] set_ev, dc_diff;

  function automatic logic hit(input bsw_sfr_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  assign async_in = {battery_control_pin_in, mon_in.line_sag, mon_in.dc_low, mon_in.main_low};

  generate
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_comb begin
        s1_next[i] = async_in[i];
        s2_next[i] = s1_reg[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      pin_prev_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      pin_prev_reg <= pin_prev_next;
    end
  end

  assign main_low = s2_reg[0];
  assign dc_low = s2_reg[1];
  assign sag = s2_reg[2];
  assign pin_now = s2_reg[3];
  assign pin_prev_next = pin_now;
  assign rising = pin_now && !pin_prev_reg;

  // Source selection
  always_comb begin
    sw_dis = swo_cfg_reg[`BSW_BIT_SWO_DIS]; // RULE1
    dc_en = !swo_cfg_reg[`BSW_BIT_PROG_HI] && !swo_cfg_reg[`BSW_BIT_PROG_LO]; // RULE3
    main_en = !swo_cfg_reg[`BSW_BIT_PROG_HI]; // RULE4
    pin_en = (pin_cfg_reg[`BSW_PIN_LO +: 2] == `BSW_PIN_PATTERN); // RULE6
    go_batt = (dc_en && dc_low) || (main_en && main_low) || (pin_en && rising); // RULE5
    // Qualify timer runs only while every enabled supply is good
    qual_cnt_next = qual_cnt_reg;
    if ((main_en && main_low) || (dc_en && dc_low) || src_reg == BSW_ON_MAIN) begin
      qual_cnt_next = '0; // RULE8
    end else if (qual_cnt_reg < QUAL_CYCLES) begin
      qual_cnt_next = qual_cnt_reg + 32'h0000_0001; // RULE9
    end
    can_return = (qual_cnt_reg >= QUAL_CYCLES) && !(pin_en && pin_now); // RULE7 RULE10
    src_next = src_reg;
    case (src_reg)
      BSW_ON_MAIN: begin
        if (!sw_dis && go_batt) begin
          src_next = BSW_ON_BATT;
        end
      end
      BSW_ON_BATT: begin
        if (sw_dis || can_return) begin
          src_next = BSW_ON_MAIN;
        end
      end
      default: src_next = BSW_ON_MAIN;
    endcase
  end

  // Monitor ADC bookkeeping
  always_comb begin
    bg_cnt_next = (bg_cnt_reg >= BG_CYCLES - 1) ? 32'h0000_0000 : bg_cnt_reg + 32'h0000_0001;
    // Background tick or software write both start a conversion
    // Tick yields to a start already pulsing; a software start is always taken
    start_next = hit(sfr_req_in, `BSW_ADDR_ADC_START) ||
                 ((bg_cnt_reg >= BG_CYCLES - 1) && !start_reg); // RULE19
    bat_read_next = mon_in.bat_ready ? mon_in.bat_value : bat_read_reg;
    dc_prev_next = mon_in.dc_ready ? mon_in.dc_value : dc_prev_reg;
    dc_diff = (mon_in.dc_value > dc_prev_reg) ? mon_in.dc_value - dc_prev_reg
                                             : dc_prev_reg - mon_in.dc_value;
    set_ev = '0;
    set_ev[`BSW_EV_DCLOW] = dc_low; // RULE21
    set_ev[`BSW_EV_SAG] = sag; // RULE24
    set_ev[`BSW_EV_DELTA] = mon_in.dc_ready && (dc_diff > delta_reg); // RULE18
    set_ev[`BSW_EV_READY] = mon_in.dc_ready; // RULE19
    set_ev[`BSW_EV_BATT] = mon_in.bat_ready ||
                           (bat_read_reg < bat_thr_reg); // RULE20
    set_ev[`BSW_EV_SWO] = (src_reg == BSW_ON_MAIN) && (src_next == BSW_ON_BATT); // RULE14 RULE16
    set_ev[`BSW_EV_RESTORE] = (src_reg == BSW_ON_BATT) && (src_next == BSW_ON_MAIN); // RULE15
  end

  // Register writes; hardware set wins over a software clear
  always_comb begin
    iep2_next = hit(sfr_req_in, `BSW_ADDR_IEIP_TWO) ? sfr_req_in.wdata : iep2_reg;
    evt_en_next = hit(sfr_req_in, `BSW_ADDR_EVT_EN) ? sfr_req_in.wdata : evt_en_reg; // RULE12
    delta_next = hit(sfr_req_in, `BSW_ADDR_ADC_DELTA) ? sfr_req_in.wdata : delta_reg;
    swo_cfg_next = hit(sfr_req_in, `BSW_ADDR_SWO_CFG) ? sfr_req_in.wdata : swo_cfg_reg;
    bat_thr_next = hit(sfr_req_in, `BSW_ADDR_BAT_THR) ? sfr_req_in.wdata : bat_thr_reg;
    pin_cfg_next = hit(sfr_req_in, `BSW_ADDR_PIN_CFG) ? sfr_req_in.wdata : pin_cfg_reg;
    flags_next = hit(sfr_req_in, `BSW_ADDR_EVT_FLAGS) ? (flags_reg & sfr_req_in.wdata)
                                                      : flags_reg; // RULE13 RULE17
    flags_next = flags_next | set_ev; // RULE16
    rdata_next = rdata_reg;
    if (sfr_req_in.rd) begin
      case (sfr_req_in.addr)
        `BSW_ADDR_IEIP_TWO: rdata_next = iep2_reg;
        `BSW_ADDR_BAT_READ: rdata_next = bat_read_reg;
        `BSW_ADDR_EVT_EN: rdata_next = evt_en_reg;
        `BSW_ADDR_ADC_DELTA: rdata_next = delta_reg;
        `BSW_ADDR_PERIPHERAL_CONFIG: begin
          rdata_next = `BSW_RST_ZERO;
          rdata_next[`BSW_BIT_SRC] = (src_reg == BSW_ON_MAIN); // RULE2
        end
        `BSW_ADDR_SWO_CFG: rdata_next = swo_cfg_reg;
        `BSW_ADDR_EVT_FLAGS: rdata_next = flags_reg;
        `BSW_ADDR_BAT_THR: rdata_next = bat_thr_reg;
        `BSW_ADDR_PIN_CFG: rdata_next = pin_cfg_reg;
        default: rdata_next = `BSW_RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      iep2_reg <= `BSW_RST_ZERO; // RULE11
      evt_en_reg <= `BSW_RST_ZERO;
      delta_reg <= `BSW_RST_ZERO;
      // Program low bit set so low-DC switching starts disabled
      swo_cfg_reg <= `BSW_RST_SWO_CFG; // RULE1 RULE3
      flags_reg <= `BSW_RST_ZERO;
      bat_thr_reg <= `BSW_RST_ZERO;
      pin_cfg_reg <= `BSW_RST_ZERO;
      bat_read_reg <= `BSW_RST_ZERO;
      dc_prev_reg <= `BSW_RST_ZERO;
      rdata_reg <= `BSW_RST_ZERO;
      start_reg <= 1'b0;
      src_reg <= BSW_ON_MAIN;
      qual_cnt_reg <= '0;
      bg_cnt_reg <= '0;
    end else begin
      iep2_reg <= iep2_next;
      evt_en_reg <= evt_en_next;
      delta_reg <= delta_next;
      swo_cfg_reg <= swo_cfg_next;
      flags_reg <= flags_next;
      bat_thr_reg <= bat_thr_next;
      pin_cfg_reg <= pin_cfg_next;
      bat_read_reg <= bat_read_next;
      dc_prev_reg <= dc_prev_next;
      rdata_reg <= rdata_next;
      start_reg <= start_next;
      src_reg <= src_next;
      qual_cnt_reg <= qual_cnt_next;
      bg_cnt_reg <= bg_cnt_next;
    end
  end

  // Rail select only; no reset or stall toward the core
  assign rail_on_battery_out = (src_reg == BSW_ON_BATT); // RULE22
  assign aux_adc_start_out = start_reg;
  assign sfr_rdata_out = rdata_reg;
  assign supply_monitor_interrupt_out =
    iep2_reg[`BSW_BIT_MASTER] && |(flags_reg & evt_en_reg); // RULE23 RULE11 RULE12

endmodule

// File: sim/bsw_mon_model.sv
// Purpose: Supply comparators and monitor converters
// Assumes: One-cycle start pulse from the block
// Notes: Values read inverted when not ready
`timescale 1ns/10ps
module bsw_mon_model
  import bsw_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Bench controls
  input wire logic start_in,
  input wire logic [2:0] levels_in,
  input wire logic [7:0] dc_in,
  input wire logic [7:0] bat_in,
  // Monitor results
  output bsw_mon_t mon_out
);
  logic [1:0] conv_reg = 2'b00;
  logic [4:0] tick_reg = 5'h00;
  always @(posedge clk_in) begin
    conv_reg <= {conv_reg[0], start_in};
    tick_reg <= tick_reg + 5'h01;
  end
  always_comb begin
    mon_out.main_low = levels_in[0];
    mon_out.dc_low = levels_in[1];
    mon_out.line_sag = levels_in[2];
    mon_out.bat_ready = (tick_reg == 5'h1f);
    mon_out.bat_value = (tick_reg == 5'h1f) ? bat_in : ~bat_in;
    mon_out.dc_ready = conv_reg[1];
    mon_out.dc_value = conv_reg[1] ? dc_in : ~dc_in;
  end
endmodule

// File: sim/bsw_switchover_props.sv
// Purpose: Port checks on the switchover block
// Assumes: Write to 0xa9 or 0xf5 acts next cycle
// Notes: Bound to every instance
`timescale 1ns/10ps
module bsw_switchover_props
  import bsw_pkg::*;
#(
  parameter int unsigned QUAL_CYCLES = 8,
  parameter int unsigned BG_CYCLES = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Bus
  input wire bsw_sfr_req_t sfr_req_in,
  input wire logic [7:0] sfr_rdata_out,
  // Monitors and results
  input wire bsw_mon_t mon_in,
  input wire logic battery_control_pin_in,
  input wire logic rail_on_battery_out,
  input wire logic aux_adc_start_out,
  input wire logic supply_monitor_interrupt_out
);
  logic [1:0] sh_next;
  logic [1:0] sh_reg;
  wire src_any = mon_in.main_low | mon_in.dc_low | battery_control_pin_in;
  always_comb begin
    sh_next = sh_reg;
    if (sfr_req_in.wr && sfr_req_in.addr == 8'ha9) sh_next[0] = sfr_req_in.wdata[1];
    if (sfr_req_in.wr && sfr_req_in.addr == 8'hf5) sh_next[1] = sfr_req_in.wdata[1];
  end
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) sh_reg <= 2'b00;
    else sh_reg <= sh_next;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_source_read: assert property (
    sfr_req_in.rd && sfr_req_in.addr == 8'hf4 |=> sfr_rdata_out[6] == !$past(rail_on_battery_out))
    else $error("source bit wrong");
  a_start_write: assert property (
    sfr_req_in.wr && sfr_req_in.addr == 8'hd8 |=> aux_adc_start_out) else $error("no start");
  a_start_pulse: assert property (
    aux_adc_start_out && !(sfr_req_in.wr && sfr_req_in.addr == 8'hd8) |=> !aux_adc_start_out)
    else $error("start too long");
  a_irq_master: assert property (
    supply_monitor_interrupt_out |-> sh_reg[0]) else $error("irq without master");
  a_disable_hold: assert property (
    sh_reg[1] && !rail_on_battery_out |=> !rail_on_battery_out) else $error("switched when off");
  a_switch_cause: assert property (
    $rose(rail_on_battery_out) |-> $past(src_any, 3) || $past(src_any, 4))
    else $error("switch without cause");
  a_return_cause: assert property (
    $fell(rail_on_battery_out) |-> !$past(mon_in.main_low, 3) || $past(sfr_req_in.wr, 2))
    else $error("early return");
  a_no_bounce: assert property (
    $rose(rail_on_battery_out) ##1 (!sfr_req_in.wr) [*3] |-> rail_on_battery_out)
    else $error("rail bounced");
  c_to_batt: cover property ($rose(rail_on_battery_out));
  c_to_main: cover property ($fell(rail_on_battery_out));
  c_irq: cover property ($rose(supply_monitor_interrupt_out));
endmodule
bind bsw_switchover bsw_switchover_props #(.QUAL_CYCLES(QUAL_CYCLES), .BG_CYCLES(BG_CYCLES))
  bsw_switchover_props_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .sfr_req_in(sfr_req_in), .sfr_rdata_out(sfr_rdata_out), .mon_in(mon_in),
  .battery_control_pin_in(battery_control_pin_in), .rail_on_battery_out(rail_on_battery_out),
  .aux_adc_start_out(aux_adc_start_out),
  .supply_monitor_interrupt_out(supply_monitor_interrupt_out));

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the switchover block
// Assumes: Short qualify and background counts
// Notes: Flag bits 2..4 move in the background, masked
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import bsw_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  bsw_sfr_req_t req = '0;
  bsw_mon_t mon;
  logic [7:0] rdata;
  logic [7:0] rv;
  logic [2:0] lvl = 3'b000;
  logic [7:0] dcv = 8'h00;
  logic [7:0] batv = 8'h00;
  logic pin = 1'b0;
  logic rail;
  logic start;
  logic irq;
  logic [31:0] seed = 32'h0000_0b12;
  int failures = 0;
  int n_checks = 0;
  int exp_flags = 0;
  always #2.5 clk_in = ~clk_in;
  bsw_switchover #(.QUAL_CYCLES(8), .BG_CYCLES(16)) bsw_switchover_inst (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .sfr_req_in(req), .sfr_rdata_out(rdata), .mon_in(mon),
    .battery_control_pin_in(pin), .rail_on_battery_out(rail), .aux_adc_start_out(start),
    .supply_monitor_interrupt_out(irq));
  bsw_mon_model bsw_mon_model_inst (.clk_in(clk_in), .start_in(start), .levels_in(lvl),
    .dc_in(dcv), .bat_in(batv), .mon_out(mon));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in) req = '{1'b1, 1'b0, a, d};
    @(negedge clk_in) req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk_in) req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_in) req.rd = 1'b0;
    rv = rdata;
  endtask
  task automatic rail_is(input logic e);
    for (int i = 0; i < 60 && rail !== e; i++) @(negedge clk_in);
    `CHK(rail, e)
  endtask
  task automatic flags_are();
    rd(8'hf8);
    `CHK(rv & 8'h63, exp_flags[7:0])
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    final_report();
  end
  initial begin
    repeat (12) @(negedge clk_in);
    sys_rst_in = 1'b0;
    rd(8'hf4); `CHK(rv[6], 1'b1)
    rd(8'hf5); `CHK(rv, 8'h01)
    rd(8'h10);
    wr(8'hf8, 8'h00);
    lvl[0] = 1'b1;
    exp_flags = 8'h20;
    rail_is(1'b1);
    flags_are();
    `CHK(irq, 1'b0)
    wr(8'hec, 8'h20);
    `CHK(irq, 1'b0)
    wr(8'ha9, 8'h02);
    `CHK(irq, 1'b1)
    wr(8'hf8, 8'h00);
    `CHK(irq, 1'b0)
    lvl[0] = 1'b0;
    exp_flags = 8'h40;
    rail_is(1'b0);
    flags_are();
    `CHK(irq, 1'b0)
    wr(8'hf5, 8'h00);
    wr(8'hf8, 8'h00);
    lvl[1] = 1'b1;
    exp_flags = 8'h21;
    rail_is(1'b1);
    flags_are();
    lvl = 3'b001;
    repeat (20) @(negedge clk_in);
    `CHK(rail, 1'b1)
    lvl = 3'b000;
    rail_is(1'b0);
    wr(8'hf5, 8'h01);
    wr(8'hff, 8'h04);
    pin = 1'b1;
    rail_is(1'b1);
    repeat (20) @(negedge clk_in);
    `CHK(rail, 1'b1)
    pin = 1'b0;
    rail_is(1'b0);
    wr(8'hf5, 8'h02);
    lvl[0] = 1'b1;
    repeat (20) @(negedge clk_in);
    `CHK(rail, 1'b0)
    lvl[0] = 1'b0;
    wr(8'hf3, 8'h10);
    dcv = rnd();
    batv = rnd();
    wr(8'hfa, rnd());
    wr(8'hd8, 8'h00);
    `CHK(start, 1'b1)
    repeat (8) @(negedge clk_in);
    lvl[2] = 1'b1;
    wr(8'hf8, 8'h00);
    // Step the input only after the clear, so the delta event cannot be wiped
    dcv = dcv ^ 8'h80;
    wr(8'hd8, 8'h00);
    repeat (40) @(negedge clk_in);
    rd(8'hf8);
    `CHK(rv[4:3], 2'b11)
    `CHK(rv[2:1], 2'b11)
    final_report();
  end
endmodule
